// [design/wwt_params.svh]
// Constants for the watchdog and wakeup timer unit
`ifndef WWT_PARAMS_SVH
`define WWT_PARAMS_SVH
`define WWT_CLK_HZ        125000000
`define WWT_LF_HZ         32000
`define WWT_LF_DIV_CYC    (`WWT_CLK_HZ / `WWT_LF_HZ)
`define WWT_TICK_DEF_US   125
`define WWT_ADDR_DATA_HI  8'hab
`define WWT_ADDR_DATA_LO  8'hac
`define WWT_ADDR_CTRL     8'had
`define WWT_ADDR_TICK_DIVIDER   8'hb5
`define WWT_RST_DATA      8'h00
`define WWT_RST_CTRL      4'h0
`define WWT_RST_TICK_DIVIDER    8'h03
`define WWT_CTRL_DIR_BIT  3
`define WWT_CTRL_BUSY_BIT 4
`define WWT_IA_WDOG       3'h0
`define WWT_IA_UPPER      3'h1
`define WWT_IA_LATCH_LO   3'h2
`define WWT_IA_COUNTER    3'h3
`define WWT_IA_CFG_A      3'h4
`define WWT_IA_CFG_B      3'h5
`define WWT_STAT_TMR_BIT  8
`define WWT_PINS_PER_CFG  4
`define WWT_FLT_CNT_1     7'h02
`define WWT_FLT_CNT_2     7'h08
`define WWT_FLT_CNT_3     7'h40
`endif

// [design/wwt_pkg.sv]
// Types for the watchdog and wakeup timer unit
package wwt_pkg;
  typedef enum logic {
    XS_IDLE,
    XS_PEND
  } wwt_xfer_state_t;

  typedef struct packed {
    logic [1:0] edge_sel;
    logic [1:0] filt_sel;
  } wwt_pin_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } wwt_sfr_req_t;
endpackage

// [design/wwt_top.sv]
// Watchdog, wakeup timer and pin wakeup logic behind four SFRs
`include "wwt_params.svh"

module wwt_top #(
  parameter int unsigned LF_DIV = `WWT_LF_DIV_CYC,
  parameter int unsigned NPIN   = 6
) (
  input  wire logic                i_clk,
  input  wire logic                i_rstn,
  input  wire wwt_pkg::wwt_sfr_req_t i_sfr,
  output logic [7:0]               o_sfr_rdata,
  input  wire logic [NPIN-1:0]     i_port0_pin,
  input  wire logic                i_mcu_sleep,
  output logic                     o_wakeup_interrupt,
  output logic                     o_force_wake,
  output logic                     o_wdt_reset
);
  import wwt_pkg::*;

  logic [11:0]     lf_cnt_reg;
  logic            lf_en_reg;
  logic [7:0]      tick_divider_reg;
  logic [7:0]      tick_cnt_reg;
  logic            tick_reg;
  logic [7:0]      data_hi_reg;
  logic [7:0]      data_lo_reg;
  logic [3:0]      ctrl_reg;
  wwt_xfer_state_t xs_reg;
  logic            busy;
  logic            ctrl_acc;
  logic            exec;
  logic            exec_wr;
  logic            exec_rd;
  logic [2:0]      ia;
  logic [15:0]     data16;
  logic [15:0]     rd_next;
  logic            wd_active_reg;
  logic [15:0]     wd_cnt_reg;
  logic [23:0]     latch_reg;
  logic [23:0]     wcnt_reg;
  logic            wen_reg;
  logic            skip_reg;
  logic            wake_evt;
  logic [3:0]      gtimer_reg;
  logic [3:0]      gt_cnt_reg;
  logic            fp_en;
  wwt_pin_cfg_t    cfg_reg [NPIN];
  logic [NPIN-1:0] pin_evt;
  logic [NPIN-1:0] pstat_reg;
  logic            tstat_reg;
  logic            stat_clr;

  assign busy     = (xs_reg == XS_PEND);
  assign ctrl_acc = i_sfr.wr && (i_sfr.addr == `WWT_ADDR_CTRL) && !busy;
  assign exec     = busy && lf_en_reg;
  assign exec_wr  = exec && ctrl_reg[`WWT_CTRL_DIR_BIT];
  assign exec_rd  = exec && !ctrl_reg[`WWT_CTRL_DIR_BIT];
  assign ia       = ctrl_reg[2:0];
  assign data16   = {data_hi_reg, data_lo_reg};
  assign stat_clr = exec_rd && ((ia == `WWT_IA_CFG_A) || (ia == `WWT_IA_CFG_B));

  // Slow clock as an enable; 125 MHz is no whole multiple, rate is 0.006% fast
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      lf_cnt_reg <= 12'h000;
      lf_en_reg  <= 1'b0;
    end else if (lf_cnt_reg == 12'(LF_DIV - 1)) begin
      lf_cnt_reg <= 12'h000;
      lf_en_reg  <= 1'b1;
    end else begin
      lf_cnt_reg <= lf_cnt_reg + 12'h001;
      lf_en_reg  <= 1'b0;
    end
  end

  // Tick generator
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      tick_cnt_reg <= 8'h00;
      tick_reg     <= 1'b0;
    end else begin
      tick_reg <= 1'b0;
      if (lf_en_reg) begin
        if (tick_cnt_reg >= tick_divider_reg) begin
          tick_cnt_reg <= 8'h00;
          tick_reg     <= 1'b1;
        end else begin
          tick_cnt_reg <= tick_cnt_reg + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      tick_divider_reg <= `WWT_RST_TICK_DIVIDER;
    end else if (i_sfr.wr && (i_sfr.addr == `WWT_ADDR_TICK_DIVIDER)) begin
      tick_divider_reg <= i_sfr.wdata;
    end
  end

  // Data registers; a bus write beats a completing read transfer
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      data_hi_reg <= `WWT_RST_DATA;
      data_lo_reg <= `WWT_RST_DATA;
    end else begin
      if (i_sfr.wr && (i_sfr.addr == `WWT_ADDR_DATA_HI)) begin
        data_hi_reg <= i_sfr.wdata;
      end else if (exec_rd) begin
        data_hi_reg <= rd_next[15:8];
      end
      if (i_sfr.wr && (i_sfr.addr == `WWT_ADDR_DATA_LO)) begin
        data_lo_reg <= i_sfr.wdata;
      end else if (exec_rd) begin
        data_lo_reg <= rd_next[7:0];
      end
    end
  end

  // Control writes while busy are dropped
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ctrl_reg <= `WWT_RST_CTRL;
      xs_reg   <= XS_IDLE;
    end else begin
      unique case (xs_reg)
        XS_IDLE: begin
          if (ctrl_acc) begin
            ctrl_reg <= i_sfr.wdata[3:0];
            xs_reg   <= XS_PEND;
          end
        end
        XS_PEND: begin
          if (lf_en_reg) begin
            xs_reg <= XS_IDLE;
          end
        end
      endcase
    end
  end

  // Indirect read mux; reserved addresses read zero
  always_comb begin
    rd_next = 16'h0000;
    unique case (ia)
      `WWT_IA_WDOG:     rd_next = wd_cnt_reg;
      `WWT_IA_UPPER:    rd_next = {wcnt_reg[23:16], latch_reg[23:16]};
      `WWT_IA_LATCH_LO: rd_next = latch_reg[15:0];
      `WWT_IA_COUNTER:  rd_next = wcnt_reg[15:0];
      `WWT_IA_CFG_A,
      `WWT_IA_CFG_B: begin
        rd_next[`WWT_STAT_TMR_BIT] = tstat_reg;
        rd_next[NPIN-1:0]          = pstat_reg;
      end
      default:          rd_next = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr.rd) begin
      unique case (i_sfr.addr)
        `WWT_ADDR_DATA_HI: o_sfr_rdata <= data_hi_reg;
        `WWT_ADDR_DATA_LO: o_sfr_rdata <= data_lo_reg;
        `WWT_ADDR_CTRL:    o_sfr_rdata <= {3'h0, busy, ctrl_reg};
        `WWT_ADDR_TICK_DIVIDER:  o_sfr_rdata <= tick_divider_reg;
        default:           o_sfr_rdata <= 8'h00;
      endcase
    end
  end

  // Watchdog; armed when the first transfer lands so a first load never races it
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wd_active_reg <= 1'b0;
    end else if (exec) begin
      wd_active_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wd_cnt_reg  <= 16'h0000;
      o_wdt_reset <= 1'b0;
    end else begin
      o_wdt_reset <= 1'b0;
      if (exec_wr && (ia == `WWT_IA_WDOG)) begin
        wd_cnt_reg <= data16;
      end else if (tick_reg && wd_active_reg) begin
        if (wd_cnt_reg == 16'h0000) begin
          o_wdt_reset <= 1'b1;
        end else begin
          wd_cnt_reg <= wd_cnt_reg - 16'h0001;
        end
      end
    end
  end

  // Wake latch
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      latch_reg  <= 24'h000000;
      gtimer_reg <= 4'h0;
    end else if (exec_wr && (ia == `WWT_IA_UPPER)) begin
      latch_reg[23:16] <= data_lo_reg;
      gtimer_reg       <= data_hi_reg[3:0];
    end else if (exec_wr && (ia == `WWT_IA_LATCH_LO)) begin
      latch_reg[15:0] <= data16;
    end
  end

  // Wake counter; first tick after a load is swallowed for the N+1..N+2 window
  assign wake_evt = tick_reg && wen_reg && !skip_reg && (wcnt_reg == 24'h000000);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wcnt_reg <= 24'h000000;
      wen_reg  <= 1'b0;
      skip_reg <= 1'b0;
    end else if (exec_wr && (ia == `WWT_IA_LATCH_LO)) begin
      wcnt_reg <= {latch_reg[23:16], data16};
      wen_reg  <= 1'b1;
      skip_reg <= 1'b1;
    end else if (exec_wr && (ia == `WWT_IA_COUNTER)) begin
      wen_reg <= 1'b0;
    end else if (tick_reg && wen_reg) begin
      if (skip_reg) begin
        skip_reg <= 1'b0;
      end else if (wake_evt) begin
        wcnt_reg <= latch_reg;
      end else begin
        wcnt_reg <= wcnt_reg - 24'h000001;
      end
    end
  end

  // Filter pulse prescaler set by the filter timer latch
  assign fp_en = lf_en_reg && (gt_cnt_reg >= gtimer_reg);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      gt_cnt_reg <= 4'h0;
    end else if (fp_en) begin
      gt_cnt_reg <= 4'h0;
    end else if (lf_en_reg) begin
      gt_cnt_reg <= gt_cnt_reg + 4'h1;
    end
  end

  function automatic logic [6:0] flt_len(input logic [1:0] code);
    logic [6:0] n;
    n = 7'h00;
    unique case (code)
      2'h0: n = 7'h00;
      2'h1: n = `WWT_FLT_CNT_1;
      2'h2: n = `WWT_FLT_CNT_2;
      2'h3: n = `WWT_FLT_CNT_3;
    endcase
    return n;
  endfunction

  // Per-pin wakeup path
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    localparam int unsigned SL = (i % `WWT_PINS_PER_CFG) * 4;
    localparam logic [2:0] CA = (i < `WWT_PINS_PER_CFG) ? `WWT_IA_CFG_A : `WWT_IA_CFG_B;
    logic       s1_reg;
    logic       s2_reg;
    logic       filt_reg;
    logic [6:0] fcnt_reg;
    logic       e1_reg;
    logic       e2_reg;
    logic       rise;
    logic       fall;

    always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
      end else begin
        s1_reg <= i_port0_pin[i];
        s2_reg <= s1_reg;
      end
    end

    always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
        cfg_reg[i] <= '0;
      end else if (exec_wr && (ia == CA)) begin
        cfg_reg[i] <= data16[SL+3:SL];
      end
    end

    // Change must persist for the selected pulse count
    always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
        filt_reg <= 1'b0;
        fcnt_reg <= 7'h00;
      end else if (fp_en) begin
        if (s2_reg == filt_reg) begin
          fcnt_reg <= 7'h00;
        end else if ((fcnt_reg + 7'h01) >= flt_len(cfg_reg[i].filt_sel)) begin
          filt_reg <= s2_reg;
          fcnt_reg <= 7'h00;
        end else begin
          fcnt_reg <= fcnt_reg + 7'h01;
        end
      end
    end

    always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
        e1_reg <= 1'b0;
        e2_reg <= 1'b0;
      end else if (lf_en_reg) begin
        e1_reg <= filt_reg;
        e2_reg <= e1_reg;
      end
    end

    assign rise       = e1_reg && !e2_reg && cfg_reg[i].edge_sel[0];
    assign fall       = !e1_reg && e2_reg && cfg_reg[i].edge_sel[1];
    assign pin_evt[i] = lf_en_reg && (rise || fall);

    always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
        pstat_reg[i] <= 1'b0;
      end else begin
        pstat_reg[i] <= (pstat_reg[i] && !stat_clr) || pin_evt[i];
      end
    end
  end

  // Set wins over the read-clear
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      tstat_reg <= 1'b0;
    end else begin
      tstat_reg <= (tstat_reg && !stat_clr) || wake_evt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_wakeup_interrupt <= 1'b0;
      o_force_wake       <= 1'b0;
    end else begin
      o_wakeup_interrupt <= wake_evt || (|pin_evt);
      o_force_wake       <= i_mcu_sleep && (tstat_reg || (|pstat_reg));
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  AST_LF_SPACING: assert property (
    lf_en_reg |=> !lf_en_reg [*7]
  ) else $error("slow enable pulses too close");

  AST_TICK_AT_DIV: assert property (
    (lf_en_reg && (tick_cnt_reg == tick_divider_reg)) |=> (tick_reg && (tick_cnt_reg == 8'h00))
  ) else $error("tick missing at divider match");

  AST_TICK_NO_EARLY: assert property (
    (lf_en_reg && (tick_cnt_reg < tick_divider_reg)) |=> !tick_reg
  ) else $error("tick before divider count");

  AST_WAKE_RELOAD: assert property (
    wake_evt |=> (o_wakeup_interrupt && (wcnt_reg == $past(latch_reg)) && tstat_reg)
  ) else $error("wake event without reload");

  AST_WAKE_ENABLE: assert property (
    (exec_wr && (ia == `WWT_IA_LATCH_LO)) |=> (wen_reg && skip_reg && (wcnt_reg[15:0] == $past(data16)))
  ) else $error("latch low write did not enable");

  AST_WAKE_DISABLE: assert property (
    (exec_wr && (ia == `WWT_IA_COUNTER)) |=> (!wen_reg && $stable(wcnt_reg))
  ) else $error("disable command ignored");

  AST_WDT_FIRE: assert property (
    (tick_reg && wd_active_reg && (wd_cnt_reg == 16'h0000) && !exec_wr) |=> o_wdt_reset
  ) else $error("watchdog expiry without reset");

  AST_WDT_STAYS: assert property (
    wd_active_reg |=> wd_active_reg
  ) else $error("watchdog disabled without reset");

  // Busy length counted here; one slow period is too long for a delay range
  logic [12:0] busy_cyc_reg;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      busy_cyc_reg <= 13'h0000;
    end else if (busy && (busy_cyc_reg != 13'h1fff)) begin
      busy_cyc_reg <= busy_cyc_reg + 13'h0001;
    end else if (!busy) begin
      busy_cyc_reg <= 13'h0000;
    end
  end

  AST_BUSY_SET: assert property (
    ctrl_acc |=> busy
  ) else $error("busy flag not raised");

  AST_BUSY_BOUND: assert property (
    busy_cyc_reg <= 13'(LF_DIV + 1)
  ) else $error("busy flag stuck");

  AST_BUSY_READ: assert property (
    (i_sfr.rd && (i_sfr.addr == `WWT_ADDR_CTRL)) |=> (o_sfr_rdata[`WWT_CTRL_BUSY_BIT] == $past(busy))
  ) else $error("busy bit misreported");

  COV_WAKE: cover property (wake_evt);
  COV_WDT: cover property (o_wdt_reset);
  COV_PIN: cover property (|pin_evt);
  COV_STAT_RD: cover property (stat_clr && tstat_reg);
endmodule

// [test/wwt_testbench.sv]
// Self-checking bench for the watchdog and wakeup timer unit
`include "wwt_params.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import wwt_pkg::*;
  // Short slow-clock divider keeps the run brief
  localparam int DIV = 8;
  localparam int T   = 2 * DIV;
  logic         i_clk;
  logic         i_rstn;
  wwt_sfr_req_t i_sfr;
  logic [7:0]   o_sfr_rdata;
  logic [5:0]   i_port0_pin;
  logic         i_mcu_sleep;
  logic         o_wakeup_interrupt;
  logic         o_force_wake;
  logic         o_wdt_reset;
  int           num_errors = 0;
  int           checked = 0;
  int           cyc = 0;
  int           n;
  logic [15:0]  rd16;
  logic [7:0]   b;
  logic [7:0]   ra [5] = '{8'hab, 8'hac, 8'had, 8'hb5, 8'hb6};
  logic [7:0]   re [5] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h00};

  wwt_top #(.LF_DIV(DIV), .NPIN(6)) dut_u (
    .i_clk              (i_clk),
    .i_rstn             (i_rstn),
    .i_sfr              (i_sfr),
    .o_sfr_rdata        (o_sfr_rdata),
    .i_port0_pin        (i_port0_pin),
    .i_mcu_sleep        (i_mcu_sleep),
    .o_wakeup_interrupt (o_wakeup_interrupt),
    .o_force_wake       (o_force_wake),
    .o_wdt_reset        (o_wdt_reset)
  );

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic final_report;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard sized well above the full sequence
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic sfr(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge i_clk) #1;
    i_sfr = '{addr: a, wdata: d, wr: w, rd: ~w};
    @(posedge i_clk) #1;
    i_sfr.wr = 1'b0;
    i_sfr.rd = 1'b0;
  endtask

  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    sfr(a, 8'h00, 1'b0);
    @(posedge i_clk) #1;
    d = o_sfr_rdata;
  endtask

  // Busy may last a whole slow period, so poll with a bound
  task automatic poll;
    logic [7:0] c;
    c = 8'h10;
    for (int k = 0; k < 100 && c[4]; k++) rd8(`WWT_ADDR_CTRL, c);
    if (c[4] !== 1'b0) chk({8'h00, c}, 16'h0000);
  endtask

  task automatic xw(input logic [2:0] ia, input logic [15:0] d);
    sfr(`WWT_ADDR_DATA_HI, d[15:8], 1'b1);
    sfr(`WWT_ADDR_DATA_LO, d[7:0], 1'b1);
    sfr(`WWT_ADDR_CTRL, {5'h01, ia}, 1'b1);
    poll();
  endtask

  task automatic xr(input logic [2:0] ia, output logic [15:0] d);
    sfr(`WWT_ADDR_CTRL, {5'h00, ia}, 1'b1);
    poll();
    rd8(`WWT_ADDR_DATA_HI, d[15:8]);
    rd8(`WWT_ADDR_DATA_LO, d[7:0]);
  endtask

  // Cycles until the chosen pulse output is seen, lim if never
  task automatic ww(input logic sel, input int lim, output int c);
    for (c = 0; c < lim; c++) begin
      @(posedge i_clk) #1;
      if ((sel ? o_wdt_reset : o_wakeup_interrupt) === 1'b1) break;
    end
  endtask

  initial begin
    i_rstn = 1'b0;
    i_sfr = '0;
    i_port0_pin = 6'h20;
    i_mcu_sleep = 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
    i_rstn = 1'b1;
    foreach (ra[i]) begin
      rd8(ra[i], b);
      chk({8'h00, b}, {8'h00, re[i]});
    end
    sfr(`WWT_ADDR_TICK_DIVIDER, 8'h01, 1'b1);
    rd8(`WWT_ADDR_TICK_DIVIDER, b);
    chk({8'h00, b}, 16'h0001);
    xw(3'h1, 16'h0512);
    xr(3'h1, rd16);
    chk({8'h00, rd16[7:0]}, 16'h0012);
    xw(3'h1, 16'h0000);
    xw(3'h2, 16'h0003);
    xr(3'h2, rd16);
    chk(rd16, 16'h0003);
    ww(1'b0, 200, n);
    chk(16'(n < 200), 16'h0001);
    ww(1'b0, 200, n);
    chk(16'(n), 16'(4 * T - 1));
    xw(3'h3, 16'hffff);
    i_mcu_sleep = 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    chk({15'h0, o_force_wake}, 16'h0001);
    xr(3'h4, rd16);
    chk(rd16, 16'h0100);
    xr(3'h5, rd16);
    chk(rd16, 16'h0000);
    chk({15'h0, o_force_wake}, 16'h0000);
    i_mcu_sleep = 1'b0;
    ww(1'b0, 200, n);
    chk(16'(n), 16'd200);
    xw(3'h4, 16'h0004);
    i_port0_pin[0] = 1'b1;
    ww(1'b0, 100, n);
    xr(3'h4, rd16);
    chk(rd16, 16'h0001);
    xw(3'h5, 16'h0080);
    i_port0_pin[5] = 1'b0;
    ww(1'b0, 100, n);
    xr(3'h5, rd16);
    chk(rd16, 16'h0020);
    xw(3'h4, 16'h00d4);
    // A short glitch meets at most one filter pulse
    i_port0_pin[1] = 1'b1;
    repeat (4) @(posedge i_clk);
    #1;
    i_port0_pin[1] = 1'b0;
    ww(1'b0, 80, n);
    chk(16'(n), 16'd80);
    i_port0_pin[1] = 1'b1;
    ww(1'b0, 100, n);
    xr(3'h4, rd16);
    chk(rd16, 16'h0002);
    i_port0_pin[1] = 1'b0;
    ww(1'b0, 100, n);
    xr(3'h4, rd16);
    chk(rd16, 16'h0002);
    sfr(`WWT_ADDR_DATA_HI, 8'h00, 1'b1);
    sfr(`WWT_ADDR_DATA_LO, 8'h05, 1'b1);
    sfr(`WWT_ADDR_CTRL, 8'h08, 1'b1);
    rd8(`WWT_ADDR_CTRL, b);
    chk({12'h000, b[3:0]}, 16'h0008);
    poll();
    ww(1'b1, 200, n);
    chk(16'(n >= 5 * T - 10 && n <= 6 * T + 4), 16'h0001);
    xw(3'h0, 16'h0100);
    xr(3'h0, rd16);
    chk(16'(rd16 <= 16'h0100 && rd16 >= 16'h00f0), 16'h0001);
    final_report();
  end
endmodule
